// ===== logic/image_readout.sv
// Capture sequencer that walks rows and columns and returns pixel bytes per read
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Control write starts a row; 256 control reads return that row's pixels.
// - Frame capture needs no address load and starts at row zero, column zero.
// - Region reads keep returning pixels until the whole region is delivered.
// - Start and end address registers hold their values across captures.
// - SPI uses the same register writes; pixel data returns on the SPI read path.
// - USB does registers over endpoint 0 and pixels over bulk endpoint 1.
// - Each capture type has a status bit, set on start, cleared after last byte.
module image_readout
  import capture_pkg::*;
#(
  parameter int ROWS = capture_pkg::ROWS_DEF,
  parameter int COLS = capture_pkg::COLS_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Address register writes (one-cycle strobes with data)
  input wire logic row_start_high_wr,
  input wire logic row_start_low_wr,
  input wire logic col_start_wr,
  input wire logic row_end_high_wr,
  input wire logic row_end_low_wr,
  input wire logic col_end_wr,
  input wire logic [7:0] wr_data,
  // Capture control write and read strobes
  input wire logic capture_control_wr,
  input wire logic capture_control_rd,
  input wire logic [1:0] host_port,
  // Pixel source from the converter
  input wire logic [capture_pkg::PIX_W-1:0] pixel_in,
  // Results
  output logic [capture_pkg::PIX_W-1:0] pixel_data,
  output logic pixel_valid,
  output logic pixel_to_spi,
  output logic pixel_to_bulk_ep,
  output logic [capture_pkg::ROW_W-1:0] cur_row,
  output logic [capture_pkg::COL_W-1:0] cur_col,
  output logic [2:0] capture_status,
  output logic [capture_pkg::ROW_W-1:0] row_start,
  output logic [capture_pkg::COL_W-1:0] col_start,
  output logic [capture_pkg::ROW_W-1:0] row_end,
  output logic [capture_pkg::COL_W-1:0] col_end
);
  import capture_pkg::*;

  localparam logic [ROW_W-1:0] LAST_ROW = ROW_W'(ROWS - 1);
  localparam logic [COL_W-1:0] LAST_COL = COL_W'(COLS - 1);

  seq_state_type state_q, state_d;
  logic [ROW_W-1:0] row_q, row_d, row_start_q, row_end_q;
  logic [COL_W-1:0] col_q, col_d, col_start_q, col_end_q;
  logic [ROW_W-1:0] row_lo_lim, row_hi_lim;
  logic [COL_W-1:0] col_lo_lim, col_hi_lim;
  logic [PIX_W-1:0] pix_q;
  logic pvalid_q, spi_q, bulk_q;
  logic [2:0] status_q, status_d;

  // Merge the low bit of a byte into the top bit of a row address, keeping bits 7:0
  function automatic logic [ROW_W-1:0] put_high(input logic [ROW_W-1:0] cur,
                                                  input logic [7:0] b);
    put_high = {b[ROW_W-9:0], cur[7:0]};
  endfunction

  wire busy = (state_q != ST_IDLE);
  wire req_row = capture_control_wr && wr_data[BIT_ROW];
  wire req_frame = capture_control_wr && wr_data[BIT_FRAME];
  wire req_region = capture_control_wr && wr_data[BIT_REGION];
  wire take = capture_control_rd && busy;
  wire at_col_end = (col_q == col_hi_lim);
  wire at_row_end = (row_q == row_hi_lim);
  wire last_byte = take && at_col_end && (state_q == ST_ROW || at_row_end);

  // Scan limits per capture kind; frame ignores the address registers
  assign col_lo_lim = (state_q == ST_REGION) ? col_start_q : FIRST_COL;
  assign col_hi_lim = (state_q == ST_REGION) ? col_end_q : LAST_COL;
  assign row_lo_lim = (state_q == ST_REGION) ? row_start_q : FIRST_ROW;
  assign row_hi_lim = (state_q == ST_REGION) ? row_end_q : LAST_ROW;

  // Next state and scan position; a new request while busy is ignored
  always_comb begin
    state_d = state_q;
    row_d = row_q;
    col_d = col_q;
    case (state_q)
      ST_IDLE: begin
        if (req_row) begin
          state_d = ST_ROW;
          row_d = row_start_q;
          col_d = FIRST_COL;
        end else if (req_frame) begin
          state_d = ST_FRAME;
          row_d = FIRST_ROW;
          col_d = FIRST_COL;
        end else if (req_region) begin
          state_d = ST_REGION;
          row_d = row_start_q;
          col_d = col_start_q;
        end
      end
      ST_ROW, ST_FRAME, ST_REGION: begin
        if (last_byte) begin
          state_d = ST_IDLE;
        end else if (take && at_col_end) begin
          row_d = ROW_W'(row_q + 1'b1);
          col_d = col_lo_lim;
        end else if (take) begin
          col_d = COL_W'(col_q + 1'b1);
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Status mirror: a start is taken only when idle, so it never coincides with the clear on the last byte
  always_comb begin
    status_d = status_q;
    if (last_byte) status_d = STATUS_RESET;
    if (!busy && capture_control_wr) begin
      status_d[BIT_ROW] = req_row;
      status_d[BIT_FRAME] = !req_row && req_frame;
      status_d[BIT_REGION] = !req_row && !req_frame && req_region;
    end
  end

  // Sequencer registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      row_q <= FIRST_ROW;
      col_q <= FIRST_COL;
      status_q <= STATUS_RESET;
    end else begin
      state_q <= state_d;
      row_q <= row_d;
      col_q <= col_d;
      status_q <= status_d;
    end
  end

  // Address registers change only on their own writes, never on a capture
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      row_start_q <= FIRST_ROW;
      col_start_q <= FIRST_COL;
      row_end_q <= LAST_ROW;
      col_end_q <= LAST_COL;
    end else begin
      if (row_start_high_wr) row_start_q <= put_high(row_start_q, wr_data);
      if (row_start_low_wr) row_start_q[7:0] <= wr_data;
      if (col_start_wr) col_start_q <= wr_data;
      if (row_end_high_wr) row_end_q <= put_high(row_end_q, wr_data);
      if (row_end_low_wr) row_end_q[7:0] <= wr_data;
      if (col_end_wr) col_end_q <= wr_data;
    end
  end

  // Pixel return, steered to the port the host is using
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pix_q <= '0;
      pvalid_q <= 1'b0;
      spi_q <= 1'b0;
      bulk_q <= 1'b0;
    end else begin
      pvalid_q <= take;
      spi_q <= take && (host_port == PORT_SPI);
      bulk_q <= take && (host_port == PORT_USB);
      if (take) pix_q <= pixel_in;
    end
  end

  assign pixel_data = pix_q;
  assign pixel_valid = pvalid_q;
  assign pixel_to_spi = spi_q;
  assign pixel_to_bulk_ep = bulk_q;
  assign cur_row = row_q;
  assign cur_col = col_q;
  assign capture_status = status_q;
  assign row_start = row_start_q;
  assign col_start = col_start_q;
  assign row_end = row_end_q;
  assign col_end = col_end_q;

  // Checks
  sequence s_row_start;
    !busy && req_row;
  endsequence
  AST_ROW_STATUS: assert property (@(posedge core_clk) disable iff (!nrst)
    s_row_start |=> capture_status[BIT_ROW] && cur_col == FIRST_COL)
    else $error("row status or column not set on row start");
  AST_FRAME_ORIGIN: assert property (@(posedge core_clk) disable iff (!nrst)
    (!busy && !req_row && req_frame) |=> cur_row == FIRST_ROW && cur_col == FIRST_COL)
    else $error("frame did not start at origin");
  AST_REGION_ORIGIN: assert property (@(posedge core_clk) disable iff (!nrst)
    (!busy && !req_row && !req_frame && req_region) |=>
      cur_row == $past(row_start_q) && cur_col == $past(col_start_q))
    else $error("region did not start at start address");
  AST_COL_ASCEND: assert property (@(posedge core_clk) disable iff (!nrst)
    (take && !at_col_end) |=> cur_col == $past(col_q) + 8'h01)
    else $error("column did not advance by one");
  AST_PIX_VALID: assert property (@(posedge core_clk) disable iff (!nrst)
    take |=> pixel_valid && pixel_data == $past(pixel_in))
    else $error("pixel not returned after read");
  AST_LAST_CLEARS: assert property (@(posedge core_clk) disable iff (!nrst)
    last_byte |=> capture_status == STATUS_RESET && !busy)
    else $error("status not cleared after last byte");
  AST_ADDR_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    (!row_start_high_wr && !row_start_low_wr && !col_start_wr) |=> $stable(row_start_q)
      && $stable(col_start_q))
    else $error("start address changed without a write");
  AST_END_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    (!row_end_high_wr && !row_end_low_wr && !col_end_wr) |=> $stable(row_end_q)
      && $stable(col_end_q))
    else $error("end address changed without a write");
  AST_SPI_ROUTE: assert property (@(posedge core_clk) disable iff (!nrst)
    (take && host_port == PORT_SPI) |=> pixel_to_spi && !pixel_to_bulk_ep)
    else $error("spi pixel misrouted");
  AST_USB_ROUTE: assert property (@(posedge core_clk) disable iff (!nrst)
    (take && host_port == PORT_USB) |=> pixel_to_bulk_ep && !pixel_to_spi)
    else $error("usb pixel misrouted");
  AST_ROW_WRAP: assert property (@(posedge core_clk) disable iff (!nrst)
    (take && at_col_end && !last_byte) |=> cur_row == $past(row_q) + 9'h001)
    else $error("row did not advance at end of row");
endmodule // image_readout
`default_nettype wire

// ===== logic/capture_pkg.sv
// Shared constants for the fingerprint image readout sequencer
`default_nettype none
package capture_pkg;
  localparam int ROWS_DEF = 300;
  localparam int COLS_DEF = 256;
  localparam int ROW_W = 9;
  localparam int COL_W = 8;
  localparam int PIX_W = 8;
  localparam logic [ROW_W-1:0] FIRST_ROW = 9'h000;
  localparam logic [COL_W-1:0] FIRST_COL = 8'h00;
  // Capture request bit positions in the control byte and the status mirror
  localparam int BIT_ROW = 0;
  localparam int BIT_FRAME = 1;
  localparam int BIT_REGION = 2;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  // Host port selection
  localparam logic [1:0] PORT_PARALLEL = 2'h0;
  localparam logic [1:0] PORT_SPI = 2'h1;
  localparam logic [1:0] PORT_USB = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ROW = 4'h2,
    ST_FRAME = 4'h4,
    ST_REGION = 4'h8
  } seq_state_type;
endpackage
`default_nettype wire

// ===== verification/pixel_source_model.sv
// Converter stand-in returning a position-coded byte for the addressed pixel
`timescale 1ns/1ps
`default_nettype none
module pixel_source_model
  import capture_pkg::*;
(
  // Scan position from the sequencer
  input wire logic [capture_pkg::ROW_W-1:0] cur_row,
  input wire logic [capture_pkg::COL_W-1:0] cur_col,
  // Converted byte
  output logic [capture_pkg::PIX_W-1:0] pixel_in
);
  import capture_pkg::*;

  // Always enabled and tuned, so every capture finds a ready sensor; distinct bytes
  // per position make a skipped or repeated column show up
  assign pixel_in = 8'(cur_row * 37 + cur_col * 5) ^ 8'h5a;
endmodule // pixel_source_model
`default_nettype wire

// ===== verification/fingerprint_image_retrieval_tb.sv
// Self-checking bench for the image readout sequencer
`timescale 1ns/1ps
`default_nettype none
module fingerprint_image_retrieval_tb;
  import capture_pkg::*;
  localparam int ROWS = 20; // Short array keeps the frame run small
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [6:0] strb = 7'h00;
  logic [7:0] wd = 8'h00;
  logic rd = 1'b0;
  logic [1:0] hp = PORT_PARALLEL;
  logic [7:0] pin, pd, ccol, cs, ce;
  logic pv, psp, pbk;
  logic [8:0] crow, rs, re;
  logic [2:0] st;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] exq [$];
  initial forever #2 core_clk = ~core_clk;
  image_readout #(.ROWS(ROWS), .COLS(256)) i_image_readout (.core_clk(core_clk), .nrst(nrst),
    .row_start_high_wr(strb[0]), .row_start_low_wr(strb[1]), .col_start_wr(strb[2]),
    .row_end_high_wr(strb[3]), .row_end_low_wr(strb[4]), .col_end_wr(strb[5]), .wr_data(wd),
    .capture_control_wr(strb[6]), .capture_control_rd(rd), .host_port(hp), .pixel_in(pin),
    .pixel_data(pd), .pixel_valid(pv), .pixel_to_spi(psp), .pixel_to_bulk_ep(pbk),
    .cur_row(crow), .cur_col(ccol), .capture_status(st), .row_start(rs), .col_start(cs),
    .row_end(re), .col_end(ce));
  pixel_source_model i_pixel_source_model (.cur_row(crow), .cur_col(ccol), .pixel_in(pin));
  function automatic logic [7:0] pix(int r, int c);
    return 8'(r * 37 + c * 5) ^ 8'h5a;
  endfunction
  task automatic chk(string n, logic [8:0] e, logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One strobe per write; strobe index 6 is the capture control
  task automatic wr(int i, logic [7:0] d);
    @(posedge core_clk);
    strb <= 7'(1 << i);
    wd <= d;
    @(posedge core_clk);
    strb <= 7'h00;
  endtask
  task automatic load(int r0, int c0, int r1, int c1);
    wr(0, 8'(r0 >> 8));
    wr(1, 8'(r0));
    wr(2, 8'(c0));
    wr(3, 8'(r1 >> 8));
    wr(4, 8'(r1));
    wr(5, 8'(c1));
  endtask
  // Start, poke a refused start while busy, then read every byte, optionally with gaps
  task automatic capture(logic [7:0] ctl, int b, int r0, int r1, int c0, int c1, bit stall);
    wr(6, ctl);
    #1 chk("status on start", 9'(1 << b), 9'(st));
    wr(6, 8'h01);
    #1 chk("status while busy", 9'(1 << b), 9'(st));
    for (int r = r0; r <= r1; r++) begin
      for (int c = c0; c <= c1; c++) begin
        // An SPI host spends a fresh read command at the start of every row
        if (c == c0 && hp == PORT_SPI) begin
          @(posedge core_clk);
          rd <= 1'b0;
        end
        while (stall && $urandom_range(3) == 0) begin
          @(posedge core_clk);
          rd <= 1'b0;
        end
        @(posedge core_clk);
        rd <= 1'b1;
        exq.push_back(pix(r, c));
      end
    end
    @(posedge core_clk);
    rd <= 1'b0;
    @(posedge core_clk);
    #1 chk("status after last byte", 9'h000, 9'(st));
    @(posedge core_clk);
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk("idle read ignored", 9'h000, 9'(pv));
    chk("bytes outstanding", 9'h000, 9'(exq.size()));
  endtask
  // Every delivered byte is matched in order and routed to the selected port
  always @(negedge core_clk) begin
    if (pv === 1'b1) begin
      chk("pixel_data", 9'(exq.size() > 0 ? exq.pop_front() : ~pd), 9'(pd));
      chk("spi route", 9'(hp == PORT_SPI), 9'(psp));
      chk("bulk route", 9'(hp == PORT_USB), 9'(pbk));
    end
  end
  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    summarize();
  end
  initial begin
    int r0, r1, c0, c1;
    void'($urandom(32'hfcee));
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    #1 chk("row_end reset", 9'(ROWS - 1), re);
    chk("col_end reset", 9'h0ff, 9'(ce));
    chk("status reset", 9'h000, 9'(st));
    load(261, 0, 0, 0);
    chk("row high and low pair", 9'h105, rs);
    // Row on every host port; all request bits set must still pick the row
    for (int p = 0; p < 3; p++) begin
      @(posedge core_clk);
      hp <= 2'(p);
      r0 = $urandom_range(ROWS - 1);
      load(r0, $urandom_range(255), ROWS - 1, 255);
      capture(p == 2 ? 8'h07 : 8'h01, BIT_ROW, r0, r0, 0, 255, p == 1);
    end
    // Regions, one per host port: far corner single pixel, then random spans with stalls
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk);
      hp <= 2'(k);
      r0 = (k == 0) ? ROWS - 1 : $urandom_range(ROWS - 1);
      r1 = (k == 0) ? r0 : r0 + $urandom_range(2);
      if (r1 >= ROWS) r1 = ROWS - 1;
      c0 = (k == 0) ? 255 : $urandom_range(255);
      c1 = (k == 0) ? c0 : c0 + $urandom_range(12);
      if (c1 > 255) c1 = 255;
      load(r0, c0, r1, c1);
      chk("col_start", 9'(c0), 9'(cs));
      chk("row_end", 9'(r1), re);
      capture(8'h04, BIT_REGION, r0, r1, c0, c1, 1'b1);
    end
    capture(8'h04, BIT_REGION, r0, r1, c0, c1, 1'b0);
    capture(8'h02, BIT_FRAME, 0, ROWS - 1, 0, 255, 1'b0);
    chk("row_start kept", 9'(r0), rs);
    chk("col_end kept", 9'(c1), 9'(ce));
    // Reset one cycle after a frame start, before any byte is read, drops the capture and the loaded addresses
    wr(6, 8'h02);
    @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    #1 chk("status after mid reset", 9'h000, 9'(st));
    chk("row_start after mid reset", 9'h000, rs);
    chk("row_end after mid reset", 9'(ROWS - 1), re);
    @(posedge core_clk);
    nrst <= 1'b1;
    capture(8'h01, BIT_ROW, 0, 0, 0, 255, 1'b0);
    summarize();
  end
endmodule // fingerprint_image_retrieval_tb
`default_nettype wire
